// File: osc_pkg.sv
// Package with constants and types for the oscillator source configuration block
package osc_pkg;

   // Configuration word geometry
   localparam int          CFG_W          = 24;
   localparam logic [23:0] SEL_IMPL_MASK  = 24'h000003;
   localparam logic [23:0] CFG_IMPL_MASK  = 24'h0000E7;
   localparam int          GRP_LSB        = 0;
   localparam int          KIND_LSB       = 0;
   localparam int          PIN2_BIT       = 2;
   localparam int          GEAR_BIT       = 5;
   localparam int          CKSM_LSB       = 6;

   // Initial source group codes
   localparam logic [1:0]  GRP_RC         = 2'h0;
   localparam logic [1:0]  GRP_RC_PLL     = 2'h1;
   localparam logic [1:0]  GRP_PRI        = 2'h2;
   localparam logic [1:0]  GRP_PRI_PLL    = 2'h3;

   // Primary oscillator kind codes
   localparam logic [1:0]  KIND_DRIVEN    = 2'h0;
   localparam logic [1:0]  KIND_RSVD      = 2'h1;
   localparam logic [1:0]  KIND_XTAL      = 2'h2;
   localparam logic [1:0]  KIND_OFF       = 2'h3;

   // Start-up wait and PLL
   localparam int          STARTUP_W      = 10;
   localparam int          STARTUP_CYCLES = 1024;
   localparam logic [9:0]  STARTUP_LAST   = 10'(STARTUP_CYCLES - 1);
   localparam logic [5:0]  PLL_GAIN       = 6'h20;

   // APB register byte offsets
   localparam logic [7:0]  REG_SRC_SEL    = 8'h00;
   localparam logic [7:0]  REG_OSC_CFG    = 8'h04;
   localparam logic [7:0]  REG_STATUS     = 8'h08;
   localparam logic [7:0]  REG_IRQ_STAT   = 8'h0C;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h10;

   // Interrupt event bits
   localparam int          EV_W           = 4;
   localparam int          EV_LOCK_UP     = 0;
   localparam int          EV_LOCK_DOWN   = 1;
   localparam int          EV_STARTUP     = 2;
   localparam int          EV_BAD_COMBO   = 3;

   // Sequencer states
   typedef enum logic [4:0] {
      ST_LATCH  = 5'h01,
      ST_DECIDE = 5'h02,
      ST_WAIT   = 5'h04,
      ST_RUN    = 5'h08,
      ST_SLEEP  = 5'h10
   } osc_state_e;

   // Status register layout, LSB last
   typedef struct packed {
      logic       xtal_mode;
      logic       driven_mode;
      logic       pll_sel;
      logic       freq_high;
      logic       combo_valid;
      logic       monitor_en;
      logic       switch_en;
      logic       released;
      logic       pll_lock;
      logic [2:0] cur_source;
   } osc_status_s;

   // APB request bundle
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } osc_apb_req_s;

endpackage

// File: osc_startup_timer.sv
// Start-up wait timer counting oscillator edges from the first oscillator pin
`timescale 1ns/10ps
module osc_startup_timer (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic osc_in,
   input  wire logic start,
   input  wire logic run,
   output logic      done
);

   typedef struct packed {
      logic                          sync1;
      logic                          sync2;
      logic                          prev;
      logic [osc_pkg::STARTUP_W-1:0] count;
      logic                          done;
   } osc_tmr_s;

   osc_tmr_s r_q;
   osc_tmr_s r_d;
   logic     edge_seen;

   // Rising edge taken from the second synchroniser stage only
   assign edge_seen = r_q.sync2 & ~r_q.prev;
   assign done      = r_q.done;

   // Next state: 10-bit count of oscillator cycles
   always_comb begin
      r_d       = r_q;
      r_d.sync1 = osc_in;
      r_d.sync2 = r_q.sync1;
      r_d.prev  = r_q.sync2;
      if (start) begin
         r_d.count = '0;
         r_d.done  = 1'b0;
      end else if (run && edge_seen && !r_q.done) begin
         r_d.count = r_q.count + 10'h001;
         if (r_q.count == osc_pkg::STARTUP_LAST) begin
            r_d.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

endmodule

// File: osc_source_config.sv
// Oscillator source configuration: latch, decode, start-up wait, lock status, APB registers
//
// Notes on behaviour
// - The initial source group picks internal RC, RC with PLL, primary, or primary with PLL.
// - Switch/monitor field 1x disables both, 01 enables switching only, 00 enables both.
// - The gear bit selects the low range when 0 and the high range when 1, for RC and PLL.
// - With the pin-two clock output bit set the clock output drives pin two outside crystal mode, else it is off.
// - Primary kind 11 is off, 10 is crystal high speed, 00 is driven clock, 01 is reserved.
// - Unimplemented configuration bits read as zero (23..8, 4 and 3 of the configuration word, 23..2 of the source word).
// - After power-on reset the source comes jointly from group and kind.
// - Valid pairs are RC with kind 11, crystal with kind 10, and driven clock with kind 00.
// - The start-up timer is a 10-bit counter of 1024 oscillator cycles before release.
// - The start-up wait applies only in crystal mode, at power-on and on wake from sleep.
// - The PLL gain is fixed at 32.
// - A read-only status bit follows the PLL lock signal, set on lock and cleared on loss; it reads zero while the PLL is not selected.
// - In driven-clock mode with output, pin one is an input and pin two shows clock over two.
// - In driven-clock mode with I/O, pin two is general I/O and the feedback element is off.
// - With switching disabled the fields drive the selection and the source status shows it.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module osc_source_config (
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ,
   // Nonvolatile configuration words
   input  wire logic [23:0] NV_SOURCE_SELECT,
   input  wire logic [23:0] NV_OSC_CONFIG,
   // Oscillator pins and PLL
   input  wire logic        OSC_PIN_ONE_I,
   output logic             OSC_PIN_ONE_O,
   output logic             OSC_PIN_ONE_OE,
   input  wire logic        OSC_PIN_TWO_I,
   output logic             OSC_PIN_TWO_O,
   output logic             OSC_PIN_TWO_OE,
   input  wire logic        PLL_LOCK_IN,
   // General I/O requests from the port logic
   input  wire logic        PIN1_GPIO_O,
   input  wire logic        PIN1_GPIO_OE,
   input  wire logic        PIN2_GPIO_O,
   input  wire logic        PIN2_GPIO_OE,
   output logic             PIN2_GPIO_I,
   // Power management
   input  wire logic        SLEEP_REQ,
   input  wire logic        WAKE_REQ,
   // Oscillator controls
   output logic             RC_OSC_EN,
   output logic             PRIMARY_EN,
   output logic             FEEDBACK_EN,
   output logic             PLL_EN,
   output logic [5:0]       PLL_MULT,
   output logic             FREQ_HIGH,
   output logic             SWITCH_EN,
   output logic             MONITOR_EN,
   output logic             SYS_CLK_RELEASE,
   output logic [2:0]       CUR_SOURCE
);

   // Whole state of the block
   typedef struct packed {
      osc_pkg::osc_state_e          st;
      logic [23:0]                  sel_word;
      logic [23:0]                  cfg_word;
      logic                         lock_s1;
      logic                         lock_s2;
      logic                         lock_q;
      logic                         div_q;
      logic                         released;
      logic                         tmr_start;
      logic [osc_pkg::EV_W-1:0]     irq_stat;
      logic [osc_pkg::EV_W-1:0]     irq_mask;
      logic [31:0]                  prdata;
      logic                         pslverr;
   } osc_core_s;

   osc_core_s             r_q;
   osc_core_s             r_d;
   osc_pkg::osc_apb_req_s req;
   osc_pkg::osc_status_s  status;

   // Fields of the latched words
   logic [1:0]               grp;
   logic [1:0]               kind;
   logic [1:0]               cksm;
   logic                     pin2_on;
   logic                     gear;

   // Source and mode decode
   logic                     grp_primary;
   logic                     combo_valid;
   logic [1:0]               eff_grp;
   logic                     xtal_mode;
   logic                     driven_mode;
   logic                     pll_sel;
   logic                     pin2_clk;

   // Lock, start-up and events
   logic                     lock_now;
   logic                     tmr_done;
   logic                     wait_over;
   logic [osc_pkg::EV_W-1:0] events;

   // Bus decode
   logic                     apb_setup;
   logic                     apb_wr;
   logic                     addr_known;
   logic                     addr_ro;

   // Request bundle
   assign req.sel    = PSEL;
   assign req.enable = PENABLE;
   assign req.write  = PWRITE;
   assign req.addr   = PADDR;
   assign req.wdata  = PWDATA;

   // Field decode from the latched words
   assign grp     = r_q.sel_word[osc_pkg::GRP_LSB +: 2];
   assign kind    = r_q.cfg_word[osc_pkg::KIND_LSB +: 2];
   assign cksm    = r_q.cfg_word[osc_pkg::CKSM_LSB +: 2];

   // Single-bit options
   assign pin2_on = r_q.cfg_word[osc_pkg::PIN2_BIT];
   assign gear    = r_q.cfg_word[osc_pkg::GEAR_BIT];

   // Joint source choice; illegal pairs fall back to internal RC
   assign grp_primary = (grp == osc_pkg::GRP_PRI) || (grp == osc_pkg::GRP_PRI_PLL);
   assign combo_valid = grp_primary ?
                        ((kind == osc_pkg::KIND_XTAL) || (kind == osc_pkg::KIND_DRIVEN)) :
                        (kind == osc_pkg::KIND_OFF);
   assign eff_grp     = combo_valid ? grp : osc_pkg::GRP_RC;

   // Modes only for a valid primary pair
   assign xtal_mode   = combo_valid && grp_primary && (kind == osc_pkg::KIND_XTAL);
   assign driven_mode = combo_valid && grp_primary && (kind == osc_pkg::KIND_DRIVEN);

   // PLL in both PLL groups
   assign pll_sel     = (eff_grp == osc_pkg::GRP_RC_PLL) || (eff_grp == osc_pkg::GRP_PRI_PLL);

   // Crystal drives pin two itself, so the clock output is only for the other modes
   assign pin2_clk    = pin2_on && !xtal_mode;

   // Gated lock: reads zero when the PLL is not selected
   assign lock_now = r_q.lock_s2 && pll_sel && (r_q.st != osc_pkg::ST_LATCH);

   // First wait cycle still shows the done flag of an earlier start
   assign wait_over = (r_q.st == osc_pkg::ST_WAIT) && tmr_done && !r_q.tmr_start;

   // Start-up timer on the first oscillator pin
   // Cleared on each entry to the wait, counts only while waiting
   osc_startup_timer u_tmr (
      .clk    (CLK),
      .resetn (RESETN),
      .osc_in (OSC_PIN_ONE_I),
      .start  (r_q.tmr_start),
      .run    (r_q.st == osc_pkg::ST_WAIT),
      .done   (tmr_done)
   );

   // Hardware events feeding the sticky status
   always_comb begin
      events                        = '0;
      events[osc_pkg::EV_LOCK_UP]   = lock_now && !r_q.lock_q;
      events[osc_pkg::EV_LOCK_DOWN] = !lock_now && r_q.lock_q;
      events[osc_pkg::EV_STARTUP]   = wait_over;
      events[osc_pkg::EV_BAD_COMBO] = (r_q.st == osc_pkg::ST_DECIDE) && !combo_valid;
   end

   // Status word
   always_comb begin
      status             = '0;
      status.cur_source  = {1'b0, eff_grp};
      status.pll_lock    = r_q.lock_q;
      status.released    = r_q.released;
      status.switch_en   = ~cksm[1];
      status.monitor_en  = (cksm == 2'h0);
      status.combo_valid = combo_valid;
      status.freq_high   = gear;
      status.pll_sel     = pll_sel;
      status.driven_mode = driven_mode;
      status.xtal_mode   = xtal_mode;
   end

   // APB phase decode
   assign apb_setup  = req.sel && !req.enable;
   assign apb_wr     = req.sel && req.enable && req.write;
   assign addr_known = (req.addr == osc_pkg::REG_SRC_SEL) || (req.addr == osc_pkg::REG_OSC_CFG) ||
                       (req.addr == osc_pkg::REG_STATUS) || (req.addr == osc_pkg::REG_IRQ_STAT) ||
                       (req.addr == osc_pkg::REG_IRQ_MASK);

   // Configuration and status are read only
   assign addr_ro    = (req.addr == osc_pkg::REG_SRC_SEL) || (req.addr == osc_pkg::REG_OSC_CFG) ||
                       (req.addr == osc_pkg::REG_STATUS);

   // Next state
   always_comb begin
      r_d           = r_q;
      r_d.tmr_start = 1'b0;
      // Lock level through two flops, then the gated copy
      r_d.lock_s1   = PLL_LOCK_IN;
      r_d.lock_s2   = r_q.lock_s1;
      r_d.lock_q    = lock_now;
      // Pin-two clock at half the system rate
      r_d.div_q     = pin2_clk ? ~r_q.div_q : 1'b0;

      // Sequencer
      unique case (r_q.st)
         osc_pkg::ST_LATCH: begin
            // Words caught once after reset release, never written again
            r_d.sel_word = NV_SOURCE_SELECT & osc_pkg::SEL_IMPL_MASK;
            r_d.cfg_word = NV_OSC_CONFIG & osc_pkg::CFG_IMPL_MASK;
            r_d.st       = osc_pkg::ST_DECIDE;
         end

         // Crystal needs the start-up wait, others run at once
         osc_pkg::ST_DECIDE: begin
            if (xtal_mode) begin
               r_d.tmr_start = 1'b1;
               r_d.st        = osc_pkg::ST_WAIT;
            end else begin
               r_d.released  = 1'b1;
               r_d.st        = osc_pkg::ST_RUN;
            end
         end

         // Release after the counted oscillator cycles
         osc_pkg::ST_WAIT: begin
            if (wait_over) begin
               r_d.released = 1'b1;
               r_d.st       = osc_pkg::ST_RUN;
            end
         end

         // Clock held back while asleep
         osc_pkg::ST_RUN: begin
            if (SLEEP_REQ) begin
               r_d.released = 1'b0;
               r_d.st       = osc_pkg::ST_SLEEP;
            end
         end

         // Wake restarts the oscillator path
         osc_pkg::ST_SLEEP: begin
            if (WAKE_REQ) begin
               if (xtal_mode) begin
                  r_d.tmr_start = 1'b1;
                  r_d.st        = osc_pkg::ST_WAIT;
               end else begin
                  r_d.released  = 1'b1;
                  r_d.st        = osc_pkg::ST_RUN;
               end
            end
         end

         // Unknown code: start over
         default: begin
            r_d.st = osc_pkg::ST_LATCH;
         end
      endcase

      // Sticky events, write one to clear, set wins
      r_d.irq_stat = r_q.irq_stat | events;
      if (apb_wr && (req.addr == osc_pkg::REG_IRQ_STAT)) begin
         r_d.irq_stat = (r_q.irq_stat & ~req.wdata[osc_pkg::EV_W-1:0]) | events;
      end

      // Mask written by software
      if (apb_wr && (req.addr == osc_pkg::REG_IRQ_MASK)) begin
         r_d.irq_mask = req.wdata[osc_pkg::EV_W-1:0];
      end

      // Read data and error prepared in the setup phase
      if (apb_setup) begin
         r_d.prdata  = '0;
         r_d.pslverr = !addr_known || (req.write && addr_ro);
         // Unmapped reads return zero
         if (!req.write) begin
            unique case (req.addr)
               osc_pkg::REG_SRC_SEL:  r_d.prdata = {8'h00, r_q.sel_word};
               osc_pkg::REG_OSC_CFG:  r_d.prdata = {8'h00, r_q.cfg_word};
               osc_pkg::REG_STATUS:   r_d.prdata = 32'(status);
               osc_pkg::REG_IRQ_STAT: r_d.prdata = 32'(r_q.irq_stat);
               osc_pkg::REG_IRQ_MASK: r_d.prdata = 32'(r_q.irq_mask);
               default:               r_d.prdata = '0;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         r_q    <= '0;
         r_q.st <= osc_pkg::ST_LATCH;
      end else begin
         r_q <= r_d;
      end
   end

   // Bus outputs
   assign PRDATA  = r_q.prdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = r_q.pslverr;

   // Interrupt: any unmasked sticky bit
   assign IRQ     = |(r_q.irq_stat & r_q.irq_mask);

   // Oscillator enables and range
   assign RC_OSC_EN       = !grp_primary || !combo_valid;
   assign PRIMARY_EN      = grp_primary && combo_valid;
   assign FEEDBACK_EN     = xtal_mode;
   assign PLL_EN          = pll_sel && (r_q.st != osc_pkg::ST_SLEEP);

   // Fixed gain and range
   assign PLL_MULT        = osc_pkg::PLL_GAIN;
   assign FREQ_HIGH       = gear;

   // Switching, monitor and source status
   assign SWITCH_EN       = status.switch_en;
   assign MONITOR_EN      = status.monitor_en;
   assign SYS_CLK_RELEASE = r_q.released;
   assign CUR_SOURCE      = status.cur_source;

   // Pin one: clock input in primary modes, general I/O otherwise
   assign OSC_PIN_ONE_O   = PIN1_GPIO_O;
   assign OSC_PIN_ONE_OE  = PRIMARY_EN ? 1'b0 : PIN1_GPIO_OE;

   // Pin two: clock output, crystal, or general I/O
   assign OSC_PIN_TWO_O   = pin2_clk ? r_q.div_q : PIN2_GPIO_O;
   assign OSC_PIN_TWO_OE  = xtal_mode ? 1'b0 : (pin2_clk ? 1'b1 : PIN2_GPIO_OE);

   // Pin two input always reaches the port
   assign PIN2_GPIO_I     = OSC_PIN_TWO_I;

endmodule

// File: osc_src_props.sv
// Concurrent checks on the ports of the oscillator source configuration block
`timescale 1ns/10ps
module osc_src_props (
   input wire logic       CLK,
   input wire logic       RESETN,
   input wire logic       OSC_PIN_ONE_I,
   input wire logic       OSC_PIN_ONE_OE,
   input wire logic       OSC_PIN_TWO_I,
   input wire logic       OSC_PIN_TWO_O,
   input wire logic       OSC_PIN_TWO_OE,
   input wire logic       PIN2_GPIO_OE,
   input wire logic       PIN2_GPIO_I,
   input wire logic       SLEEP_REQ,
   input wire logic       RC_OSC_EN,
   input wire logic       PRIMARY_EN,
   input wire logic       FEEDBACK_EN,
   input wire logic       PLL_EN,
   input wire logic [5:0] PLL_MULT,
   input wire logic       SWITCH_EN,
   input wire logic       MONITOR_EN,
   input wire logic       FREQ_HIGH,
   input wire logic       SYS_CLK_RELEASE,
   input wire logic [2:0] CUR_SOURCE
);
   logic [2:0]  sync_q;
   logic [10:0] edges_q;
   logic [1:0]  age_q;
   logic        co_q;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);

   // Pin-one edges seen while the clock is held back, saturating at 1024
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync_q  <= 3'h0;
         edges_q <= 11'h000;
         age_q   <= 2'h0;
      end else begin
         sync_q  <= {sync_q[1:0], OSC_PIN_ONE_I};
         edges_q <= SYS_CLK_RELEASE ? 11'h000 :
                    edges_q + {10'h000, sync_q[1] && !sync_q[2] && !edges_q[10]};
         age_q   <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      end
   end

   // Clock-out mode seen at the pin
   assign co_q = OSC_PIN_TWO_OE && !PIN2_GPIO_OE && SYS_CLK_RELEASE;

   chk_mult_fixed: assert property (PLL_EN |-> PLL_MULT == 6'h20)
      else $error("PLL gain not 32");
   chk_monitor_switch: assert property (MONITOR_EN |-> SWITCH_EN)
      else $error("monitor on without switching");
   chk_source_map: assert property (!CUR_SOURCE[2] && (CUR_SOURCE[0] || !PLL_EN))
      else $error("source status wrong");
   chk_rc_primary: assert property ((PRIMARY_EN || CUR_SOURCE[1]) |-> !RC_OSC_EN)
      else $error("RC on beside primary");
   chk_pin_one_in: assert property (PRIMARY_EN |-> !OSC_PIN_ONE_OE)
      else $error("pin one driven in primary mode");
   chk_clkout_half: assert property (co_q && $past(co_q) |-> OSC_PIN_TWO_O != $past(OSC_PIN_TWO_O))
      else $error("clock out not half rate");
   chk_gpio_input: assert property (PIN2_GPIO_I == OSC_PIN_TWO_I)
      else $error("pin two input not passed");
   chk_feedback_xtal: assert property (FEEDBACK_EN |-> !OSC_PIN_TWO_OE && !OSC_PIN_ONE_OE)
      else $error("feedback with pin driven");
   chk_startup_count: assert property ($rose(SYS_CLK_RELEASE) && FEEDBACK_EN |-> edges_q >= 11'h3FC)
      else $error("released before start-up count");
   chk_quick_release: assert property ($rose(RESETN) |-> ##[2:4] (SYS_CLK_RELEASE || FEEDBACK_EN))
      else $error("no prompt release");
   chk_release_holds: assert property (SYS_CLK_RELEASE && !SLEEP_REQ |=> SYS_CLK_RELEASE)
      else $error("release dropped");
   chk_config_frozen: assert property (age_q == 2'h3 |-> $stable({SWITCH_EN, MONITOR_EN, FREQ_HIGH, CUR_SOURCE}))
      else $error("configuration changed");

   cover property ($rose(SYS_CLK_RELEASE) && FEEDBACK_EN);
   cover property (SYS_CLK_RELEASE && SLEEP_REQ);
   cover property (MONITOR_EN);
   cover property (co_q);
endmodule

bind osc_source_config osc_src_props u_props (
   .CLK, .RESETN, .OSC_PIN_ONE_I, .OSC_PIN_ONE_OE, .OSC_PIN_TWO_I, .OSC_PIN_TWO_O,
   .OSC_PIN_TWO_OE, .PIN2_GPIO_OE, .PIN2_GPIO_I, .SLEEP_REQ, .RC_OSC_EN, .PRIMARY_EN,
   .FEEDBACK_EN, .PLL_EN, .PLL_MULT, .SWITCH_EN, .MONITOR_EN, .FREQ_HIGH,
   .SYS_CLK_RELEASE, .CUR_SOURCE
);

// File: osc_xtal_model.sv
// Behavioural crystal or driven clock source on the first oscillator pin
`timescale 1ns/10ps
module osc_xtal_model (
   input  wire logic run,
   input  wire logic slow,
   output logic      osc
);
   // Full swing clock while powered, flat while stopped; slow mode stretches start-up
   initial begin
      osc = 1'h0;
      forever begin
         if (run) begin
            #(slow ? 260 : 160) osc = ~osc;
         end else begin
            @(run);
         end
      end
   end
endmodule

// File: osc_tb.sv
// Self-checking bench for the oscillator source configuration block
`timescale 1ns/10ps
module testbench;
   logic        clk, resetn, psel, penable, pwrite, pll_lock, slow, sleep_req, wake_req;
   logic        p1o, p1oe, p2o, p2oe, pin2_in, osc_pin_one, osc_pin_one_o, osc_pin_one_oe, osc_pin_two_o, osc_pin_two_oe, p2i;
   logic        pready, pslverr, irq, rc_en, pri_en, fb_en, pll_en, freq_hi, sw_en, mon_en;
   logic        rel, ok, xt, dr, co;
   logic [1:0]  eg;
   logic [7:0]  paddr, c;
   logic [31:0] pwdata, prdata, seed;
   logic [23:0] nv_sel, nv_cfg;
   logic [5:0]  pll_mult;
   logic [2:0]  cur_src;
   logic [34:0] exp_q[$];
   int          err_total, tests_run, cyc;

   osc_source_config uut (
      .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .IRQ(irq), .NV_SOURCE_SELECT(nv_sel), .NV_OSC_CONFIG(nv_cfg), .OSC_PIN_ONE_I(osc_pin_one),
      .OSC_PIN_ONE_O(osc_pin_one_o), .OSC_PIN_ONE_OE(osc_pin_one_oe), .OSC_PIN_TWO_I(pin2_in),
      .OSC_PIN_TWO_O(osc_pin_two_o), .OSC_PIN_TWO_OE(osc_pin_two_oe), .PLL_LOCK_IN(pll_lock),
      .PIN1_GPIO_O(p1o), .PIN1_GPIO_OE(p1oe), .PIN2_GPIO_O(p2o), .PIN2_GPIO_OE(p2oe),
      .PIN2_GPIO_I(p2i), .SLEEP_REQ(sleep_req), .WAKE_REQ(wake_req), .RC_OSC_EN(rc_en),
      .PRIMARY_EN(pri_en), .FEEDBACK_EN(fb_en), .PLL_EN(pll_en), .PLL_MULT(pll_mult),
      .FREQ_HIGH(freq_hi), .SWITCH_EN(sw_en), .MONITOR_EN(mon_en),
      .SYS_CLK_RELEASE(rel), .CUR_SOURCE(cur_src)
   );
   osc_xtal_model u_src (.run(pri_en), .slow(slow), .osc(osc_pin_one));

   // Clock at 20 MHz
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected status word for the current configuration
   function automatic logic [31:0] sts(input logic lk);
      return {20'h0, xt, dr, eg[0], c[5], ok, c[7:6] == 2'h0, !c[7], 1'h1, lk, 1'h0, eg};
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bad(input string m);
      err_total++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic cmp_sig(input logic [31:0] a, input logic [31:0] e, input string m);
      tests_run++;
      if (a !== e) bad(m);
   endtask

   task automatic cmp_apb(input logic [34:0] x);
      tests_run++;
      if ((x[32] && prdata !== x[31:0]) || (x[34] && pslverr !== x[33])) bad("apb answer");
   endtask

   // One APB transfer; the expected answer goes to the queue first
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [34:0] ex);
      exp_q.push_back(ex);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'h0, a, 32'h0, {2'h2, 1'h1, d});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'h1, a, d, {1'h1, e, 33'h0});
   endtask

   task automatic wait_rel(input int lo, input int hi);
      int n;
      n = 0;
      while (rel !== 1'h1 && n <= hi) begin
         @(negedge clk); // Settled outputs
         n++;
      end
      cmp_sig({31'h0, n >= lo && n <= hi}, 32'h1, "release timing");
   endtask

   // Power-on with one group and kind, then check everything visible
   task automatic run_cfg(input logic [1:0] g, input logic [1:0] k);
      logic [31:0] r;
      @(posedge clk);
      r = xs();
      nv_sel <= {r[23:2], g};
      nv_cfg <= {r[31:10], k};
      {p1o, p1oe, pin2_in, p2o, p2oe} <= r[4:0];
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      c = {r[15:10], k} & osc_pkg::CFG_IMPL_MASK[7:0];
      ok = g[1] ? (k == osc_pkg::KIND_XTAL || k == osc_pkg::KIND_DRIVEN) : k == osc_pkg::KIND_OFF;
      eg = ok ? g : osc_pkg::GRP_RC;
      xt = ok && g[1] && k == osc_pkg::KIND_XTAL;
      dr = ok && g[1] && k == osc_pkg::KIND_DRIVEN;
      co = c[2] && !xt;
      wait_rel(xt ? 6138 : 0, xt ? 9000 : 4);
      cmp_sig({cur_src, pll_en, pri_en, rc_en, freq_hi, sw_en, mon_en, fb_en, pll_mult},
              {1'h0, eg, eg[0], eg[1], !eg[1], c[5], !c[7], c[7:6] == 2'h0, xt, 6'h20},
              "decode");
      cmp_sig({osc_pin_one_oe, osc_pin_one_o, osc_pin_two_oe, p2i, (co || xt) ? 1'h0 : osc_pin_two_o},
              {!eg[1] && r[3], r[4], co || (!xt && r[0]), r[2], !(co || xt) && r[1]},
              "pins");
      rd(osc_pkg::REG_SRC_SEL, {30'h0, g});
      rd(osc_pkg::REG_OSC_CFG, {24'h0, c});
      wr(osc_pkg::REG_OSC_CFG, ~r, 1'h1);
      rd(osc_pkg::REG_OSC_CFG, {24'h0, c});
      rd(osc_pkg::REG_STATUS, sts(1'h0));
      wr(8'h40, r, 1'h1);
      apb(1'h0, 8'h40, 32'h0, {2'h3, 1'h1, 32'h0});
      wr(osc_pkg::REG_IRQ_MASK, 32'h8, 1'h0);
      rd(osc_pkg::REG_IRQ_MASK, 32'h8);
      cmp_sig({31'h0, irq}, {31'h0, !ok}, "bad combo irq");
      wr(osc_pkg::REG_IRQ_STAT, 32'h8, 1'h0);
      @(posedge clk);
      cmp_sig({31'h0, irq}, 32'h0, "irq clear");
      pll_lock <= 1'h1;
      repeat (5) @(posedge clk);
      rd(osc_pkg::REG_STATUS, sts(eg[0]));
      pll_lock <= 1'h0;
      repeat (5) @(posedge clk);
      rd(osc_pkg::REG_STATUS, sts(1'h0));
      sleep_req <= 1'h1;
      @(posedge clk);
      sleep_req <= 1'h0;
      repeat (2) @(posedge clk);
      cmp_sig({31'h0, rel}, 32'h0, "sleep release");
      slow <= xt;
      wake_req <= 1'h1;
      @(posedge clk);
      wake_req <= 1'h0;
      wait_rel(xt ? 10230 : 0, xt ? 12000 : 4);
      slow <= 1'h0;
      $display("config group %0d kind %0d done", g, k);
   endtask

   // Compare every completed transfer with the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready) begin
         if (exp_q.size() == 0)
            bad("unexpected transfer");
         else
            cmp_apb(exp_q.pop_front());
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad("timeout");
         end_of_test();
      end
   end

   // Main sequence over every group and kind pair
   initial begin
      seed = 32'h00000038;
      {resetn, psel, penable, pwrite, pll_lock, slow, sleep_req, wake_req} = 8'h00;
      {p1o, p1oe, p2o, p2oe, pin2_in} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      nv_sel = 24'h0;
      nv_cfg = 24'h0;
      for (int i = 0; i < 16; i++) begin
         run_cfg(i[3:2], i[1:0]);
      end
      end_of_test();
   end
endmodule
